// [core/ogm_cfg.svh]
// Register map, field layout, reset values and timing for the output stage
`ifndef OGM_CFG_SVH
`define OGM_CFG_SVH

`define OGM_ADDR_W 8
`define OGM_DATA_W 8

`define OGM_ADDR_PWR_CTRL 8'h21
`define OGM_ADDR_VOL_LHP 8'h24
`define OGM_ADDR_VOL_RHP 8'h25
`define OGM_ADDR_VOL_LSPK 8'h26
`define OGM_ADDR_VOL_RSPK 8'h27
`define OGM_ADDR_DRV_LHP 8'h28
`define OGM_ADDR_DRV_RHP 8'h29
`define OGM_ADDR_DRV_LSPK 8'h2a

`define OGM_VOL_ROUTE_BIT 7
`define OGM_VOL_GAIN_MSB 6
`define OGM_VOL_GAIN_LSB 0
`define OGM_VOL_GAIN_W 7
`define OGM_VOL_GAIN_RST 7'h7f
`define OGM_VOL_ROUTE_RST 1'h0
`define OGM_VOL_MUTE_CODE 7'h7f

`define OGM_HP_GAIN_MSB 6
`define OGM_HP_GAIN_LSB 3
`define OGM_HP_GAIN_W 4
`define OGM_HP_GAIN_RST 4'h0
`define OGM_HP_UNMUTE_BIT 2
`define OGM_HP_UNMUTE_RST 1'h0
`define OGM_HP_PD_HIZ_BIT 1
`define OGM_HP_PD_HIZ_RST 1'h1
`define OGM_APPLIED_BIT 0

`define OGM_SPK_GAIN_MSB 4
`define OGM_SPK_GAIN_LSB 3
`define OGM_SPK_GAIN_W 2
`define OGM_SPK_GAIN_RST 2'h0
`define OGM_SPK_UNMUTE_BIT 2
`define OGM_SPK_UNMUTE_RST 1'h0

`define OGM_PWR_CM_BIT 0
`define OGM_PWR_CM_RST 1'h0

`define OGM_CLK_NS 4
`define OGM_STEP_NS 1000
`define OGM_STEP_CYCLES ((`OGM_STEP_NS + `OGM_CLK_NS - 1) / `OGM_CLK_NS)
`define OGM_STEP_CNT_W 9

`endif

// [core/ogm_gain_ramp.sv]
// Steps an applied gain code one unit at a time toward its target
`timescale 1ns/10ps
`include "ogm_cfg.svh"

module ogm_gain_ramp
    import ogm_pkg::*;
#(
    parameter int W = 7,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Programmed code and its write strobe
    input wire logic [W-1:0] target,
    input wire logic load,
    // Applied code
    output logic [W-1:0] cur_q,
    output logic done
);

    ogm_ramp_state_t state_q;
    logic [`OGM_STEP_CNT_W-1:0] cnt_q;
    logic [W-1:0] next_cur;

    assign next_cur = (cur_q < target) ? cur_q + 1'b1 : cur_q - 1'b1;

    // A write keeps the flag low for at least one step period
    assign done = (state_q == OGM_ST_IDLE) && (cur_q == target) && !load;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= OGM_ST_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                OGM_ST_IDLE:
                begin
                    if (load || cur_q != target)
                    begin
                        state_q <= OGM_ST_WAIT;
                        cnt_q <= `OGM_STEP_CNT_W'(`OGM_STEP_CYCLES - 1);
                    end
                end
                OGM_ST_WAIT:
                begin
                    if (load)
                        cnt_q <= `OGM_STEP_CNT_W'(`OGM_STEP_CYCLES - 1);
                    else if (cnt_q == '0)
                        state_q <= OGM_ST_STEP;
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                OGM_ST_STEP:
                begin
                    if (load || (cur_q != target && next_cur != target))
                    begin
                        state_q <= OGM_ST_WAIT;
                        cnt_q <= `OGM_STEP_CNT_W'(`OGM_STEP_CYCLES - 1);
                    end
                    else
                        state_q <= OGM_ST_IDLE;
                end
                default:
                    state_q <= OGM_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cur_q <= RST_VAL;
        else if (state_q == OGM_ST_STEP && cur_q != target)
            cur_q <= next_cur;
    end

endmodule

// [core/ogm_out_regs.sv]
// Output driver volume, gain, mute and power-down register bank
`timescale 1ns/10ps
`include "ogm_cfg.svh"

module ogm_out_regs
    import ogm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial control interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`OGM_ADDR_W-1:0] reg_addr,
    input wire logic [`OGM_DATA_W-1:0] reg_wdata,
    output logic [`OGM_DATA_W-1:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // Analog volume paths: 0 left hp, 1 right hp, 2 left spk, 3 right spk
    output logic [3:0][`OGM_VOL_GAIN_W-1:0] vol_atten_q,
    output logic [3:0] vol_route_q,
    output logic [3:0] vol_mute_q,
    // Headphone drivers: 0 left, 1 right
    output logic [1:0][`OGM_HP_GAIN_W-1:0] hp_gain_q,
    output logic [1:0] hp_unmute_q,
    output logic [1:0] hp_pd_hiz_q,
    // Left speaker driver
    output logic [`OGM_SPK_GAIN_W-1:0] spk_gain_q,
    output logic spk_unmute_q,
    // Power-on control
    output logic cm_divider_sel_q
);

    logic [3:0][`OGM_DATA_W-1:0] vol_reg_q;
    logic [3:0] vol_wr;
    logic [3:0] vol_done;

    logic [1:0][`OGM_HP_GAIN_W-1:0] hp_gain_reg_q;
    logic [1:0] hp_unmute_reg_q;
    logic [1:0] hp_pd_hiz_reg_q;
    logic [1:0] hp_wr;
    logic [1:0] hp_done;
    logic [1:0] hp_applied;

    logic [`OGM_SPK_GAIN_W-1:0] spk_gain_reg_q;
    logic spk_unmute_reg_q;
    logic spk_wr;
    logic spk_done;
    logic spk_applied;

    logic pwr_cm_reg_q;
    logic pwr_wr;

    logic [`OGM_DATA_W-1:0] rdata_d;

    // Write decode
    assign vol_wr[0] = reg_wr && (reg_addr == `OGM_ADDR_VOL_LHP);
    assign vol_wr[1] = reg_wr && (reg_addr == `OGM_ADDR_VOL_RHP);
    assign vol_wr[2] = reg_wr && (reg_addr == `OGM_ADDR_VOL_LSPK);
    assign vol_wr[3] = reg_wr && (reg_addr == `OGM_ADDR_VOL_RSPK);
    assign hp_wr[0] = reg_wr && (reg_addr == `OGM_ADDR_DRV_LHP);
    assign hp_wr[1] = reg_wr && (reg_addr == `OGM_ADDR_DRV_RHP);
    assign spk_wr = reg_wr && (reg_addr == `OGM_ADDR_DRV_LSPK);
    assign pwr_wr = reg_wr && (reg_addr == `OGM_ADDR_PWR_CTRL);

    // Analog volume paths
    genvar gv;
    generate
        for (gv = 0; gv < 4; gv++)
        begin : g_vol
            // Volume register keeps route bit and attenuation code
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    vol_reg_q[gv] <= {`OGM_VOL_ROUTE_RST,
                        `OGM_VOL_GAIN_RST};
                else if (vol_wr[gv])
                    vol_reg_q[gv] <= reg_wdata;
            end

            ogm_gain_ramp #(
                .W(`OGM_VOL_GAIN_W),
                .RST_VAL(`OGM_VOL_GAIN_RST)
            ) u_ramp (
                .clk(clk),
                .rst(rst),
                .target(vol_reg_q[gv][`OGM_VOL_GAIN_MSB:`OGM_VOL_GAIN_LSB]),
                .load(vol_wr[gv]),
                .cur_q(vol_atten_q[gv]),
                .done(vol_done[gv])
            );

            ogm_vol_decode u_dec (
                .clk(clk),
                .rst(rst),
                .vol_reg(vol_reg_q[gv]),
                .route_q(vol_route_q[gv]),
                .mute_q(vol_mute_q[gv])
            );
        end
    endgenerate

    // Headphone drivers
    generate
        for (gv = 0; gv < 2; gv++)
        begin : g_hp
            // Stored driver fields; reserved bit 7 is dropped
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    hp_gain_reg_q[gv] <= `OGM_HP_GAIN_RST;
                else if (hp_wr[gv])
                    hp_gain_reg_q[gv] <=
                        reg_wdata[`OGM_HP_GAIN_MSB:`OGM_HP_GAIN_LSB];
            end

            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    hp_unmute_reg_q[gv] <= `OGM_HP_UNMUTE_RST;
                else if (hp_wr[gv])
                    hp_unmute_reg_q[gv] <=
                        reg_wdata[`OGM_HP_UNMUTE_BIT];
            end

            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    hp_pd_hiz_reg_q[gv] <= `OGM_HP_PD_HIZ_RST;
                else if (hp_wr[gv])
                    hp_pd_hiz_reg_q[gv] <=
                        reg_wdata[`OGM_HP_PD_HIZ_BIT];
            end

            ogm_gain_ramp #(
                .W(`OGM_HP_GAIN_W),
                .RST_VAL(`OGM_HP_GAIN_RST)
            ) u_ramp (
                .clk(clk),
                .rst(rst),
                .target(hp_gain_reg_q[gv]),
                .load(hp_wr[gv]),
                .cur_q(hp_gain_q[gv]),
                .done(hp_done[gv])
            );

            // Driver gain and its analog volume both settled
            assign hp_applied[gv] = hp_done[gv] && vol_done[gv];
        end
    endgenerate

    // Driver controls follow the stored fields one cycle later
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hp_unmute_q <= {2{`OGM_HP_UNMUTE_RST}};
        else
            hp_unmute_q <= hp_unmute_reg_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hp_pd_hiz_q <= {2{`OGM_HP_PD_HIZ_RST}};
        else
            hp_pd_hiz_q <= hp_pd_hiz_reg_q;
    end

    // Left speaker driver
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            spk_gain_reg_q <= `OGM_SPK_GAIN_RST;
        else if (spk_wr)
            spk_gain_reg_q <=
                reg_wdata[`OGM_SPK_GAIN_MSB:`OGM_SPK_GAIN_LSB];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            spk_unmute_reg_q <= `OGM_SPK_UNMUTE_RST;
        else if (spk_wr)
            spk_unmute_reg_q <= reg_wdata[`OGM_SPK_UNMUTE_BIT];
    end

    // Unmute reaches the speaker stage two cycles after the write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            spk_unmute_q <= `OGM_SPK_UNMUTE_RST;
        else
            spk_unmute_q <= spk_unmute_reg_q;
    end

    ogm_gain_ramp #(
        .W(`OGM_SPK_GAIN_W),
        .RST_VAL(`OGM_SPK_GAIN_RST)
    ) u_spk_ramp (
        .clk(clk),
        .rst(rst),
        .target(spk_gain_reg_q),
        .load(spk_wr),
        .cur_q(spk_gain_q),
        .done(spk_done)
    );

    // Speaker settles with its gain stage and its volume path
    assign spk_applied = spk_done && vol_done[2];

    // Power-on control: only the common-mode source bit lives here
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pwr_cm_reg_q <= `OGM_PWR_CM_RST;
        else if (pwr_wr)
            pwr_cm_reg_q <= reg_wdata[`OGM_PWR_CM_BIT];
    end

    // Weak common mode from the supply divider while the bit is zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cm_divider_sel_q <= !`OGM_PWR_CM_RST;
        else
            cm_divider_sel_q <= !pwr_cm_reg_q;
    end

    // Read mux; reserved bits read zero, status bits are read-only
    always_comb
    begin
        rdata_d = '0;
        case (reg_addr)
            `OGM_ADDR_VOL_LHP:
                rdata_d = vol_reg_q[0];
            `OGM_ADDR_VOL_RHP:
                rdata_d = vol_reg_q[1];
            `OGM_ADDR_VOL_LSPK:
                rdata_d = vol_reg_q[2];
            `OGM_ADDR_VOL_RSPK:
                rdata_d = vol_reg_q[3];
            `OGM_ADDR_DRV_LHP:
            begin
                rdata_d[`OGM_HP_GAIN_MSB:`OGM_HP_GAIN_LSB] =
                    hp_gain_reg_q[0];
                rdata_d[`OGM_HP_UNMUTE_BIT] = hp_unmute_reg_q[0];
                rdata_d[`OGM_HP_PD_HIZ_BIT] = hp_pd_hiz_reg_q[0];
                rdata_d[`OGM_APPLIED_BIT] = hp_applied[0];
            end
            `OGM_ADDR_DRV_RHP:
            begin
                rdata_d[`OGM_HP_GAIN_MSB:`OGM_HP_GAIN_LSB] =
                    hp_gain_reg_q[1];
                rdata_d[`OGM_HP_UNMUTE_BIT] = hp_unmute_reg_q[1];
                rdata_d[`OGM_HP_PD_HIZ_BIT] = hp_pd_hiz_reg_q[1];
                rdata_d[`OGM_APPLIED_BIT] = hp_applied[1];
            end
            `OGM_ADDR_DRV_LSPK:
            begin
                rdata_d[`OGM_SPK_GAIN_MSB:`OGM_SPK_GAIN_LSB] =
                    spk_gain_reg_q;
                rdata_d[`OGM_SPK_UNMUTE_BIT] = spk_unmute_reg_q;
                rdata_d[`OGM_APPLIED_BIT] = spk_applied;
            end
            `OGM_ADDR_PWR_CTRL:
                rdata_d[`OGM_PWR_CM_BIT] = pwr_cm_reg_q;
            default:
                rdata_d = '0;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata_q <= '0;
        else if (reg_rd)
            reg_rdata_q <= rdata_d;
    end

    // One valid pulse per read strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rvalid_q <= 1'h0;
        else
            reg_rvalid_q <= reg_rd;
    end

endmodule

// [core/ogm_pkg.sv]
// Types shared by the output stage register block
package ogm_pkg;

    // Gray coded along idle -> wait -> step
    typedef enum logic [1:0] {
        OGM_ST_IDLE = 2'b00,
        OGM_ST_WAIT = 2'b01,
        OGM_ST_STEP = 2'b11
    } ogm_ramp_state_t;

endpackage

// [core/ogm_vol_decode.sv]
// Route and mute decode of one analog volume path
`timescale 1ns/10ps
`include "ogm_cfg.svh"

module ogm_vol_decode
    import ogm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Programmed volume register
    input wire logic [`OGM_DATA_W-1:0] vol_reg,
    // Driver feed
    output logic route_q,
    output logic mute_q
);

    logic [`OGM_VOL_GAIN_W-1:0] gain;

    assign gain = vol_reg[`OGM_VOL_GAIN_MSB:`OGM_VOL_GAIN_LSB];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            route_q <= `OGM_VOL_ROUTE_RST;
            mute_q <= !`OGM_VOL_ROUTE_RST
                && (`OGM_VOL_GAIN_RST == `OGM_VOL_MUTE_CODE);
        end
        else
        begin
            route_q <= vol_reg[`OGM_VOL_ROUTE_BIT];
            mute_q <= !vol_reg[`OGM_VOL_ROUTE_BIT]
                && (gain == `OGM_VOL_MUTE_CODE);
        end
    end

endmodule

// [sim/ogm_out_regs_properties.sv]
// Port assertions for the output stage register bank
`timescale 1ns/10ps

module ogm_out_regs_properties
    import ogm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    // Volume paths
    input wire logic [3:0][6:0] vol_atten_q,
    input wire logic [3:0] vol_route_q,
    input wire logic [3:0] vol_mute_q,
    // Drivers and power-on control
    input wire logic [1:0][3:0] hp_gain_q,
    input wire logic [1:0] hp_unmute_q,
    input wire logic [1:0] hp_pd_hiz_q,
    input wire logic [1:0] spk_gain_q,
    input wire logic spk_unmute_q,
    input wire logic cm_divider_sel_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    vol_mute_a:
        assert property (reg_wr && reg_addr == 8'h24 |-> ##2
            vol_mute_q[0] == ($past(reg_wdata, 2) == 8'h7f))
        else $error("path mute decode wrong");
    vol_route_a:
        assert property (reg_wr && reg_addr == 8'h27 |-> ##2
            vol_route_q[3] == $past(reg_wdata[7], 2))
        else $error("path route wrong");
    hp_unmute_a:
        assert property (reg_wr && reg_addr == 8'h28 |-> ##2
            hp_unmute_q[0] == $past(reg_wdata[2], 2))
        else $error("headphone unmute wrong");
    hp_pd_a:
        assert property (reg_wr && reg_addr == 8'h29 |-> ##2
            hp_pd_hiz_q[1] == $past(reg_wdata[1], 2))
        else $error("headphone power-down state wrong");
    spk_unmute_a:
        assert property (reg_wr && reg_addr == 8'h2a |-> ##2
            spk_unmute_q == $past(reg_wdata[2], 2))
        else $error("speaker unmute wrong");
    cm_sel_a:
        assert property (reg_wr && reg_addr == 8'h21 |-> ##2
            cm_divider_sel_q == !$past(reg_wdata[0], 2))
        else $error("common mode select wrong");
    hp_step_a:
        assert property ($changed(hp_gain_q[0]) |->
            hp_gain_q[0] == $past(hp_gain_q[0]) + 4'h1 ||
            $past(hp_gain_q[0]) == hp_gain_q[0] + 4'h1)
        else $error("headphone gain jumped");
    flag_drop_a:
        assert property (reg_wr && reg_addr == 8'h2a ##1
            reg_rd && reg_addr == 8'h2a |=> reg_rvalid_q && !reg_rdata_q[0])
        else $error("applied flag not cleared by write");
endmodule

bind ogm_out_regs ogm_out_regs_properties u_props (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .vol_atten_q(vol_atten_q),
    .vol_route_q(vol_route_q), .vol_mute_q(vol_mute_q),
    .hp_gain_q(hp_gain_q), .hp_unmute_q(hp_unmute_q),
    .hp_pd_hiz_q(hp_pd_hiz_q), .spk_gain_q(spk_gain_q),
    .spk_unmute_q(spk_unmute_q), .cm_divider_sel_q(cm_divider_sel_q));

// [sim/tb.sv]
// Self-checking bench for the output stage register bank
`timescale 1ns/10ps

module tb;
    logic clk;
    logic rst;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_q;
    logic reg_rvalid_q;
    logic [3:0][6:0] vol_atten_q;
    logic [3:0] vol_route_q;
    logic [3:0] vol_mute_q;
    logic [1:0][3:0] hp_gain_q;
    logic [1:0] hp_unmute_q;
    logic [1:0] hp_pd_hiz_q;
    logic [1:0] spk_gain_q;
    logic spk_unmute_q;
    logic cm_divider_sel_q;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed;
    int r;
    int n;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [7:0] d;

    ogm_out_regs u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .vol_atten_q(vol_atten_q), .vol_route_q(vol_route_q),
        .vol_mute_q(vol_mute_q), .hp_gain_q(hp_gain_q),
        .hp_unmute_q(hp_unmute_q), .hp_pd_hiz_q(hp_pd_hiz_q),
        .spk_gain_q(spk_gain_q), .spk_unmute_q(spk_unmute_q),
        .cm_divider_sel_q(cm_divider_sel_q));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = v;
    endtask

    // Queue holds mask and masked expected read data
    task automatic rd(logic [7:0] a, logic [7:0] v, logic [7:0] m);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_wr = 1'b0;
        reg_addr = a;
        exp_q.push_back({m, v & m});
    endtask

    task automatic idle(int c);
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (c) @(negedge clk);
    endtask

    task automatic chk_rst();
        for (int i = 0; i < 4; i++)
            check("atten", 8'(vol_atten_q[i]), 8'h7f);
        check("mute", 8'(vol_mute_q), 8'h0f);
        check("route", 8'(vol_route_q), 8'h00);
        check("hp gain", 8'(hp_gain_q), 8'h00);
        check("hp unmute", 8'(hp_unmute_q), 8'h00);
        check("hp hiz", 8'(hp_pd_hiz_q), 8'h03);
        check("spk", {5'h00, spk_gain_q, spk_unmute_q}, 8'h00);
        check("cm sel", 8'(cm_divider_sel_q), 8'h01);
        rd(8'h21, 8'h00, 8'hff);
        for (int p = 0; p < 4; p++)
            rd(8'h24 + p[7:0], 8'h7f, 8'hff);
        rd(8'h28, 8'h02, 8'hfe);
        rd(8'h29, 8'h02, 8'hfe);
        rd(8'h2a, 8'h00, 8'hfe);
        rd(8'h2b, 8'h00, 8'hff);
        idle(3);
    endtask

    always @(negedge clk)
    begin
        if (reg_rvalid_q === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected rvalid", 8'h01, 8'h00);
            else
            begin
                e = exp_q.pop_front();
                check("rdata", reg_rdata_q & e[15:8],
                    e[7:0]);
            end
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end

    initial
    begin
        seed = 32'h43484ea5;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk_rst();
        $display("test reset values done");
        for (int p = 0; p < 4; p++)
        begin
            r = $random(seed);
            d = {r[0], 7'h7f};
            wr(8'h24 + p[7:0], d);
            rd(8'h24 + p[7:0], d, 8'hff);
            idle(1);
            check("route", 8'(vol_route_q[p]), 8'(r[0]));
            check("mute", 8'(vol_mute_q[p]), 8'(!r[0]));
        end
        wr(8'h24, 8'h7e);
        idle(2);
        check("mute lo", 8'({vol_route_q[0], vol_mute_q[0]}), 8'h00);
        for (n = 0; n < 600 && vol_atten_q[0] !== 7'h7e; n++)
            @(negedge clk);
        check("atten", 8'(vol_atten_q[0]), 8'h7e);
        $display("test volume paths done");
        wr(8'h21, 8'h00);
        for (int g = 0; g < 10; g++)
        begin
            d = {1'b0, g[3:0], 3'b101};
            wr(8'h28, d);
            rd(8'h28, d & 8'hfe, 8'hff);
            idle(270);
            check("hp pins", 8'({hp_unmute_q[0], hp_pd_hiz_q[0]}),
                8'h02);
            check("hp gain", 8'(hp_gain_q[0]), 8'(g[3:0]));
            rd(8'h28, d, 8'hff);
        end
        r = $random(seed);
        d = {1'b0, 4'($unsigned(r) % 10), r[2:1], 1'b0};
        wr(8'h29, d);
        idle(270);
        for (n = 0; n < 2600 && hp_gain_q[1] !== d[6:3]; n++)
            @(negedge clk);
        idle(3);
        check("hp r gain", 8'(hp_gain_q[1]), 8'(d[6:3]));
        check("hp r pins", 8'({hp_unmute_q[1], hp_pd_hiz_q[1]}),
            8'(d[2:1]));
        rd(8'h29, d | 8'h01, 8'hff);
        $display("test headphone drivers done");
        for (int c = 0; c < 4; c++)
        begin
            d = {3'b000, c[1:0], c[0], 2'b00};
            wr(8'h2a, d);
            rd(8'h2a, d, 8'hff);
            idle(270);
            check("spk", 8'({spk_gain_q, spk_unmute_q}),
                8'({c[1:0], c[0]}));
            rd(8'h2a, d | 8'h01, 8'hff);
        end
        $display("test speaker driver done");
        wr(8'h21, 8'h01);
        rd(8'h21, 8'h01, 8'hff);
        idle(2);
        check("cm sel", 8'(cm_divider_sel_q), 8'h00);
        wr(8'h21, 8'h00);
        idle(2);
        check("cm sel", 8'(cm_divider_sel_q), 8'h01);
        $display("test common mode done");
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        chk_rst();
        $display("test second reset done");
        summarize();
    end
endmodule
